// File: dv/rdc_host_model.sv
// host driver model: keeps its own copy of each write-back as the driver reads it
// assumes rdc_core write-back outputs on pclk
`timescale 1ns/1ps
`default_nettype none
module rdc_host_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        wb_valid,
   input  wire logic [19:0] wb_status,
   input  wire logic [15:0] wb_csum,
   input  wire logic [15:0] wb_ip_ident,
   output logic [2:0]       sum_flags_q,
   output logic [15:0]      ident_q,
   output logic             done_q,
   output logic [15:0]      frag_acc_q
);
   logic [16:0] acc_d;
   // fragment sums folded end-around, a good datagram ends at all ones
   assign acc_d = {1'h0, frag_acc_q} + {1'h0, wb_csum};
   // copy starts with done clear, as handed over to the device
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_flags_q <= 3'h0;
         ident_q     <= 16'h0000;
         done_q      <= 1'h0;
         frag_acc_q  <= 16'h0000;
      end else if (wb_valid) begin
         done_q      <= wb_status[rdc_pkg::ST_DESC_DONE];
         // done flags are worthless while the ignore flag is up
         sum_flags_q <= wb_status[6:4] & {3{~wb_status[rdc_pkg::ST_IGNORE_SUM]}};
         ident_q     <= wb_status[rdc_pkg::ST_IP_IDENT_VLD] ? wb_ip_ident : 16'h0000;
         if (wb_status[rdc_pkg::ST_UDP_SUM_DONE]) begin
            frag_acc_q <= acc_d[15:0] + {15'h0000, acc_d[16]};
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/rx_desc_status_checksum_bench.sv
// self-checking bench for the descriptor status and checksum block
// assumes rdc_core, rdc_host_model, one 50 MHz pclk, apb master in here
`timescale 1ns/1ps
`default_nettype none
module rx_desc_status_checksum_bench;
   logic        pclk, presetn, psel, penable, pwrite, perr, pready, pslverr, irq, wb_valid, h_done;
   logic        pkt_valid, pkt_sop, pkt_eop, pkt_in_vlan, pkt_in_ip_payload;
   logic        cls_ipv4, cls_frag, cls_has_tcp, cls_has_udp, cls_udp_sum_nonzero, cls_vlan_present;
   logic        cls_ip_sum_ok, cls_l4_sum_ok, inexact_filter_pass, last_desc;
   logic        rx_data_err, order_fault, symbol_err, crc_err;
   logic [7:0]  paddr, pkt_data;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cls_ip_ident, cls_vlan_type, wb_csum, wb_ip_ident, h_ident, h_acc;
   logic [19:0] wb_status;
   logic [11:0] wb_error;
   logic [2:0]  h_flags;
   int          failures, checked;

   rdc_core u_rdc_core (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
      .pkt_valid, .pkt_sop, .pkt_eop, .pkt_data, .pkt_in_vlan, .pkt_in_ip_payload,
      .cls_ipv4, .cls_frag, .cls_has_tcp, .cls_has_udp, .cls_udp_sum_nonzero, .cls_ip_ident,
      .cls_vlan_present, .cls_vlan_type, .cls_ip_sum_ok, .cls_l4_sum_ok, .inexact_filter_pass,
      .last_desc, .rx_data_err, .order_fault, .symbol_err, .crc_err,
      .wb_valid, .wb_status, .wb_error, .wb_csum, .wb_ip_ident
   );
   rdc_host_model u_rdc_host_model (
      .pclk, .presetn, .wb_valid, .wb_status, .wb_csum, .wb_ip_ident,
      .sum_flags_q(h_flags), .ident_q(h_ident), .done_q(h_done), .frag_acc_q(h_acc)
   );

   ////////////////////////////////////////////////////////////
   // free-running 20 ns clock
   initial begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // unadjusted ones-complement sum, big-endian pairs, odd byte padded low
   function automatic logic [15:0] xs(input int n, vs, ve, lo);
      logic [16:0] s;
      int          k;
      s = 17'h0;
      k = 0;
      for (int i = 0; i < n; i++) begin
         if ((i < vs || i >= ve) && i >= lo) begin
            s = s + ((k % 2 == 0) ? {1'h0, 8'h10 + 8'(i), 8'h00} : {9'h0, 8'h10 + 8'(i)});
            s = {1'h0, s[15:0]} + {16'h0, s[16]};
            k++;
         end
      end
      return s[15:0];
   endfunction

   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      perr = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic set_cls(input logic [13:0] c);
      {cls_ipv4, cls_frag, cls_has_tcp, cls_has_udp, cls_udp_sum_nonzero, cls_vlan_present, cls_ip_sum_ok,
       cls_l4_sum_ok, inexact_filter_pass, last_desc, rx_data_err, order_fault, symbol_err, crc_err} <= c;
   endtask

   // bytes 0x10+i; class levels held all packet since only the eop cycle counts
   task automatic send_pkt(input int n, vs, ve, ps, input logic [13:0] c, input logic [19:0] es,
                           input logic [11:0] ee, input logic [15:0] ecs, eid);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         pkt_valid         <= 1'h1;
         pkt_sop           <= (i == 0);
         pkt_eop           <= (i == n - 1);
         pkt_data          <= 8'h10 + 8'(i);
         pkt_in_vlan       <= (i >= vs && i < ve);
         pkt_in_ip_payload <= (i >= ps);
         set_cls(c);
      end
      @(posedge pclk);
      pkt_valid <= 1'h0;
      pkt_eop   <= 1'h0;
      #1;
      cmp(wb_valid, 32'h1);
      cmp(wb_status, es);
      cmp(wb_error, ee);
      cmp(wb_csum, ecs);
      cmp(wb_ip_ident, eid);
      @(posedge pclk);
      #1;
      cmp(wb_valid, 32'h0);
      cmp(h_done, 32'h1);
      cmp(h_flags, es[2] ? 3'h0 : es[6:4]);
      cmp(h_ident, es[9] ? eid : 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(1'h0, rdc_pkg::A_CTRL, 32'h0);
      cmp(rd, 32'h0);
      apb(1'h0, rdc_pkg::A_VET, 32'h0);
      cmp(rd, {16'h0, rdc_pkg::VET_RST});
      apb(1'h0, 8'h18, 32'h0);
      cmp(perr, 32'h1);
      cmp(rd, 32'h0);
   endtask

   // offload off: ignore flag up, last flag from last_desc, snapshot read-only
   task automatic t_off();
      send_pkt(10, 0, 0, 10, 14'h20f0, 20'h00087, 12'h000, xs(10, 0, 0, 0), 16'h0);
      apb(1'h1, rdc_pkg::A_LAST_8, 32'hffffffff);
      apb(1'h0, rdc_pkg::A_LAST_8, 32'h0);
      cmp(rd, 32'h00000087);
      apb(1'h0, rdc_pkg::A_ISTAT, 32'h0);
      cmp(rd, 32'h1);
      apb(1'h1, rdc_pkg::A_ISTAT, 32'h1);
   endtask

   task automatic t_vlan_tcp();
      apb(1'h1, rdc_pkg::A_CTRL, 32'h00000007);
      send_pkt(12, 4, 8, 12, 14'h2980, 20'h00069, 12'h200, xs(12, 4, 8, 0), 16'h0);
      apb(1'h0, rdc_pkg::A_ISTAT, 32'h0);
      cmp(rd, 32'h3);
   endtask

   task automatic t_frag();
      send_pkt(12, 0, 0, 6, 14'h36d0, 20'h00653, 12'h000, xs(12, 0, 0, 6), 16'h1234);
      cmp(h_acc, xs(12, 0, 0, 6));
      @(posedge pclk);
      cls_vlan_type <= 16'h88a8;
      send_pkt(9, 0, 0, 4, 14'h39d0, 20'h00243, 12'h000, xs(9, 0, 0, 0), 16'h1234);
   endtask

   // error write-back raises the error event; mask lets it out, w1c drops it
   task automatic t_err_irq();
      logic [16:0] s;
      apb(1'h1, rdc_pkg::A_ISTAT, 32'h3);
      send_pkt(11, 0, 0, 4, 14'h305f, 20'h00253, 12'hc70, xs(11, 0, 0, 4), 16'h1234);
      // driver folds the second fragment sum into the first, end-around
      s = {1'h0, xs(12, 0, 0, 6)} + {1'h0, xs(11, 0, 0, 4)};
      cmp(h_acc, 16'(s[15:0] + {15'h0000, s[16]}));
      apb(1'h0, rdc_pkg::A_ISTAT, 32'h0);
      cmp(rd, 32'h3);
      cmp(irq, 32'h0);
      apb(1'h1, rdc_pkg::A_IMASK, 32'h2);
      #1;
      cmp(irq, 32'h1);
      apb(1'h1, rdc_pkg::A_ISTAT, 32'h2);
      #1;
      cmp(irq, 32'h0);
      apb(1'h0, rdc_pkg::A_LAST_0, 32'h0);
      cmp(rd, {xs(11, 0, 0, 4), 16'h1234});
   endtask

   // write-back event unmasked; then a start offset of 2 drops the first two bytes from the sum
   task automatic t_nonip();
      apb(1'h1, rdc_pkg::A_ISTAT, 32'h3);
      apb(1'h1, rdc_pkg::A_IMASK, 32'h1);
      #1;
      cmp(irq, 32'h0);
      send_pkt(1, 0, 0, 1, 14'h00d0, 20'h00007, 12'h000, xs(1, 0, 0, 0), 16'h0);
      cmp(irq, 32'h1);
      apb(1'h1, rdc_pkg::A_CTRL, 32'h00000207);
      send_pkt(5, 0, 0, 5, 14'h00d0, 20'h00007, 12'h000, xs(5, 0, 0, 2), 16'h0);
   endtask

   task automatic complete_run();
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence: 20 cycles of reset, then each scenario in turn
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {pkt_valid, pkt_sop, pkt_eop, pkt_data, pkt_in_vlan, pkt_in_ip_payload} = '0;
      set_cls(14'h0);
      cls_ip_ident = 16'h1234;
      cls_vlan_type = 16'h8100;
      failures = 0;
      checked = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_off();
      t_vlan_tcp();
      t_frag();
      t_err_irq();
      t_nonip();
      complete_run();
   end

   // the whole run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge pclk);
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire

// File: rtl/rdc_core.sv
// receive descriptor status/error builder with packet checksum accumulation
// assumes a byte stream with parser region flags and per-packet class inputs
// valid on the last byte; all inputs synchronous to pclk
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - fragment udp valid flag on nonzero checksum
// - udp valid clear when no udp header
// - ip identification valid for ipv4 fragments
// - ipv4 sum done when ip offload ran
// - tcp sum done when l4 offload ran
// - udp sum done for fragment udp offload
// - vlan tagged when type matches programmed ethertype
// - ignore flag clears the three done flags
// - error field at bit 20, reserved zero
// - order, symbol, crc error bits reported
// - packet sum from the start offset on, minus vlan, otherwise
// - non-tcp fragments sum ip payload, ident set
// - done flag set on every write-back
// - status field at bit 0, high reserved
module rdc_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        pkt_valid,
   input  wire logic        pkt_sop,
   input  wire logic        pkt_eop,
   input  wire logic [7:0]  pkt_data,
   input  wire logic        pkt_in_vlan,
   input  wire logic        pkt_in_ip_payload,
   input  wire logic        cls_ipv4,
   input  wire logic        cls_frag,
   input  wire logic        cls_has_tcp,
   input  wire logic        cls_has_udp,
   input  wire logic        cls_udp_sum_nonzero,
   input  wire logic [15:0] cls_ip_ident,
   input  wire logic        cls_vlan_present,
   input  wire logic [15:0] cls_vlan_type,
   input  wire logic        cls_ip_sum_ok,
   input  wire logic        cls_l4_sum_ok,
   input  wire logic        inexact_filter_pass,
   input  wire logic        last_desc,
   input  wire logic        rx_data_err,
   input  wire logic        order_fault,
   input  wire logic        symbol_err,
   input  wire logic        crc_err,
   output logic             wb_valid,
   output logic [19:0]      wb_status,
   output logic [11:0]      wb_error,
   output logic [15:0]      wb_csum,
   output logic [15:0]      wb_ip_ident
);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [2:0]                  ctrl;
      logic [7:0]                  ofs;
      logic [15:0]                 vlan_ethertype_match;
      logic [rdc_pkg::IRQ_W-1:0]   istat;
      logic [rdc_pkg::IRQ_W-1:0]   imask;
      logic [24:0]                 acc_all;  // {odd, held byte, sum}
      logic [24:0]                 acc_pl;
      logic [7:0]                  cnt;
      logic                        wb_valid;
      logic [rdc_pkg::STAT_W-1:0]  status;
      logic [rdc_pkg::ERR_W-1:0]   error;
      logic [15:0]                 csum;
      logic [15:0]                 ident;
      logic [31:0]                 rdata;
      logic                        slverr;
   } rdc_state_t;

   rdc_state_t q;
   rdc_state_t d;

   ////////////////////////////////////////////////////////////////////////////////
   // ones-complement helpers
   function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};  // end-around carry
   endfunction

   // bytes pair big-endian into 16-bit words
   function automatic logic [24:0] acc_step(input logic [24:0] acc, input logic [7:0] b);
      if (acc[24]) begin
         return {1'b0, 8'h00, oc_add(acc[15:0], {acc[23:16], b})};
      end
      return {1'b1, b, acc[15:0]};
   endfunction

   // an odd trailing byte is padded with zero in the low half
   function automatic logic [15:0] acc_final(input logic [24:0] acc);
      if (acc[24]) begin
         return oc_add(acc[15:0], {acc[23:16], 8'h00});
      end
      return acc[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic [24:0] a_all;
   logic [24:0] a_pl;
   logic [7:0]  c;
   logic        frag;
   logic        ign;
   logic        ipv4_sum_done;
   logic        tcp_sum_done;
   logic        udp_sum_done;
   logic [rdc_pkg::STAT_W-1:0] st;
   logic [rdc_pkg::ERR_W-1:0]  er;
   logic [rdc_pkg::IRQ_W-1:0]  ev;

   always_comb begin
      d        = q;
      a_all    = q.acc_all;
      a_pl     = q.acc_pl;
      c        = q.cnt;
      frag     = cls_ipv4 & cls_frag;
      ign      = ~q.ctrl[rdc_pkg::CT_SUM_EN] | ~cls_ipv4;
      ipv4_sum_done     = ~ign;
      tcp_sum_done    = ipv4_sum_done & ~frag & q.ctrl[rdc_pkg::CT_L4_OFL] & (cls_has_tcp | cls_has_udp);
      udp_sum_done    = ipv4_sum_done & frag & ~cls_has_tcp & q.ctrl[rdc_pkg::CT_FRAG_UDP];
      st       = '0;
      er       = '0;
      ev       = '0;
      d.wb_valid = 1'b0;

      // stream accumulation; vlan bytes neither counted nor summed
      if (pkt_valid) begin
         if (pkt_sop) begin
            a_all = '0;
            a_pl  = '0;
            c     = '0;
         end
         if (!pkt_in_vlan) begin
            if (c >= q.ofs) begin
               a_all = acc_step(a_all, pkt_data);
            end
            if (c != 8'hff) begin
               c = c + 8'h01;  // saturates; offsets beyond 255 are not reachable
            end
         end
         if (pkt_in_ip_payload) begin
            a_pl = acc_step(a_pl, pkt_data);
         end
         d.acc_all = a_all;
         d.acc_pl  = a_pl;
         d.cnt     = c;
      end

      // descriptor write-back on the last byte
      if (pkt_valid && pkt_eop) begin
         st[rdc_pkg::ST_DESC_DONE]    = 1'b1;
         st[rdc_pkg::ST_LAST_OF_PKT]  = last_desc;
         st[rdc_pkg::ST_IGNORE_SUM]   = ign;
         st[rdc_pkg::ST_VLAN_TAGGED]  = cls_vlan_present & (cls_vlan_type == q.vlan_ethertype_match);
         st[rdc_pkg::ST_UDP_SUM_DONE] = udp_sum_done;
         st[rdc_pkg::ST_TCP_SUM_DONE] = tcp_sum_done;
         st[rdc_pkg::ST_IPV4_DONE]    = ipv4_sum_done;
         st[rdc_pkg::ST_INEXACT_PASS] = inexact_filter_pass;
         st[rdc_pkg::ST_IP_IDENT_VLD] = frag;
         // fragments without a udp header always read zero here
         st[rdc_pkg::ST_FRAG_UDP_VLD] = udp_sum_done & cls_has_udp & cls_udp_sum_nonzero;
         er[rdc_pkg::ER_RX_DATA]      = rx_data_err;
         er[rdc_pkg::ER_IPV4_SUM]     = ipv4_sum_done & ~cls_ip_sum_ok;
         er[rdc_pkg::ER_L4_SUM]       = tcp_sum_done & ~cls_l4_sum_ok;
         er[rdc_pkg::ER_ORDER_FAULT]  = order_fault;
         er[rdc_pkg::ER_SYMBOL]       = symbol_err;
         er[rdc_pkg::ER_CRC_ALIGN]    = crc_err;
         d.wb_valid = 1'b1;
         d.status   = st;
         d.error    = er;
         d.csum     = (frag & ~cls_has_tcp) ? acc_final(a_pl) : acc_final(a_all);
         d.ident    = frag ? cls_ip_ident : 16'h0000;
         ev[rdc_pkg::EV_WB]  = 1'b1;
         ev[rdc_pkg::EV_ERR] = |er;
      end

      // apb: data is latched in setup so the access phase never waits
      wr_acc   = psel & penable & pwrite;
      rd_setup = psel & ~penable;
      mapped   = (paddr == rdc_pkg::A_CTRL) | (paddr == rdc_pkg::A_VET) |
                 (paddr == rdc_pkg::A_ISTAT) | (paddr == rdc_pkg::A_IMASK) |
                 (paddr == rdc_pkg::A_LAST_8) | (paddr == rdc_pkg::A_LAST_0);
      if (rd_setup) begin
         d.slverr = ~mapped;
         unique case (paddr)
            rdc_pkg::A_CTRL:   d.rdata = {16'h0000, q.ofs, 5'h00, q.ctrl};
            rdc_pkg::A_VET:    d.rdata = {16'h0000, q.vlan_ethertype_match};
            rdc_pkg::A_ISTAT:  d.rdata = {30'h0, q.istat};
            rdc_pkg::A_IMASK:  d.rdata = {30'h0, q.imask};
            rdc_pkg::A_LAST_8: d.rdata = {q.error, q.status};
            rdc_pkg::A_LAST_0: d.rdata = {q.csum, q.ident};
            default:           d.rdata = 32'h00000000;
         endcase
      end
      d.istat = q.istat | ev;  // a new event beats a same-cycle clear
      if (wr_acc && mapped) begin
         unique case (paddr)
            rdc_pkg::A_CTRL: begin
               d.ctrl = pwdata[2:0];
               d.ofs  = pwdata[rdc_pkg::CT_OFS_LSB +: 8];  // driver leaves zero for fragment offload
            end
            rdc_pkg::A_VET:   d.vlan_ethertype_match   = pwdata[15:0];
            rdc_pkg::A_ISTAT: d.istat = (q.istat & ~pwdata[rdc_pkg::IRQ_W-1:0]) | ev;
            rdc_pkg::A_IMASK: d.imask = pwdata[rdc_pkg::IRQ_W-1:0];
            default: ;  // write-back records are read-only
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q      <= '0;
         q.ctrl <= rdc_pkg::CTRL_RST;
         q.ofs  <= rdc_pkg::OFS_RST;
         q.vlan_ethertype_match  <= rdc_pkg::VET_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata      = q.rdata;
   assign pslverr     = q.slverr & psel & penable;
   assign pready      = 1'b1;
   assign irq         = |(q.istat & q.imask);
   assign wb_valid    = q.wb_valid;
   assign wb_status   = q.status;
   assign wb_error    = q.error;
   assign wb_csum     = q.csum;
   assign wb_ip_ident = q.ident;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_last_byte;
      pkt_valid && pkt_eop;
   endsequence

   sequence s_frag_last;
      s_last_byte ##0 (cls_ipv4 && cls_frag);
   endsequence

   chk_frag_udp_valid: assert property (@(posedge pclk) disable iff (!presetn)
      s_frag_last ##0 (cls_has_udp && cls_udp_sum_nonzero && !cls_has_tcp
                       && q.ctrl[rdc_pkg::CT_FRAG_UDP] && q.ctrl[rdc_pkg::CT_SUM_EN])
      |=> wb_valid && wb_status[rdc_pkg::ST_FRAG_UDP_VLD] && wb_status[rdc_pkg::ST_IP_IDENT_VLD])
      else $error("fragment udp valid flag missing");

   chk_udp_valid_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte ##0 !cls_has_udp |=> !wb_status[rdc_pkg::ST_FRAG_UDP_VLD])
      else $error("udp valid set without udp header");

   chk_ident_valid: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte |=> wb_status[rdc_pkg::ST_IP_IDENT_VLD] == $past(cls_ipv4 && cls_frag))
      else $error("ident valid does not follow fragment class");

   chk_ignore_flags: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid && wb_status[rdc_pkg::ST_IGNORE_SUM]
      |-> wb_status[rdc_pkg::ST_IPV4_DONE:rdc_pkg::ST_UDP_SUM_DONE] == 3'b000)
      else $error("done flags set while ignore flag set");

   chk_frag_no_tcp: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid && wb_status[rdc_pkg::ST_IP_IDENT_VLD] |-> !wb_status[rdc_pkg::ST_TCP_SUM_DONE])
      else $error("tcp done set on a fragment");

   chk_nonfrag_flags: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte ##0 !cls_frag
      |=> !wb_status[rdc_pkg::ST_FRAG_UDP_VLD] && !wb_status[rdc_pkg::ST_UDP_SUM_DONE])
      else $error("udp flags set on non-fragment");

   chk_done_bit: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte |=> wb_valid && wb_status[rdc_pkg::ST_DESC_DONE]
                      ##1 (!wb_valid || $past(pkt_valid && pkt_eop)))
      else $error("write-back missing or longer than one cycle");

   chk_last_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte |=> wb_status[rdc_pkg::ST_LAST_OF_PKT] == $past(last_desc))
      else $error("last flag mismatch");

   chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid |-> ((wb_error & rdc_pkg::ERR_RSVD_MASK) == '0)
                   && ((wb_status & rdc_pkg::STAT_RSVD_MASK) == '0))
      else $error("reserved bits set in write-back");

   chk_vlan_match: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte |=> wb_status[rdc_pkg::ST_VLAN_TAGGED]
                      == $past(cls_vlan_present && (cls_vlan_type == q.vlan_ethertype_match)))
      else $error("vlan flag does not follow ethertype match");

   chk_link_errors: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte |=> wb_error[rdc_pkg::ER_ORDER_FAULT:rdc_pkg::ER_CRC_ALIGN]
                      == $past({order_fault, symbol_err, crc_err}))
      else $error("link error bits mismatch");

   chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte ##0 q.imask[rdc_pkg::EV_WB] ##1 q.imask[rdc_pkg::EV_WB] |-> irq)
      else $error("unmasked write-back event did not raise interrupt");

   chk_ipv4_done: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte |=> wb_status[rdc_pkg::ST_IPV4_DONE]
                      == $past(q.ctrl[rdc_pkg::CT_SUM_EN] && cls_ipv4))
      else $error("ipv4 done flag does not follow offload state");

   chk_tcp_done: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_byte ##0 (cls_ipv4 && !cls_frag && (cls_has_tcp || cls_has_udp)
                       && q.ctrl[rdc_pkg::CT_SUM_EN] && q.ctrl[rdc_pkg::CT_L4_OFL])
      |=> wb_status[rdc_pkg::ST_TCP_SUM_DONE])
      else $error("tcp done flag missing after l4 offload");

   // a checksum error bit is only meaningful when its offload actually ran
   chk_l4_err_gate: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid && wb_error[rdc_pkg::ER_L4_SUM] |-> wb_status[rdc_pkg::ST_TCP_SUM_DONE])
      else $error("l4 error without l4 offload");

   chk_udp_needs_ip: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid && wb_status[rdc_pkg::ST_UDP_SUM_DONE]
      |-> wb_status[rdc_pkg::ST_IPV4_DONE] && wb_status[rdc_pkg::ST_IP_IDENT_VLD])
      else $error("udp done without ipv4 done on a fragment");

   chk_ip_err_gate: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid && wb_error[rdc_pkg::ER_IPV4_SUM] |-> wb_status[rdc_pkg::ST_IPV4_DONE])
      else $error("ipv4 error without ipv4 offload");

endmodule

`default_nettype wire

// File: rtl/rdc_pkg.sv
// package for the receive descriptor status and checksum block
// assumes a single pclk domain and an apb register slave with 32-bit data
package rdc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // descriptor quadword 8 layout
   localparam int STAT_W          = 20;
   localparam int ERR_W           = 12;
   localparam int ERR_LSB         = 20;
   localparam int ST_DESC_DONE    = 0;
   localparam int ST_LAST_OF_PKT  = 1;
   localparam int ST_IGNORE_SUM   = 2;
   localparam int ST_VLAN_TAGGED  = 3;
   localparam int ST_UDP_SUM_DONE = 4;
   localparam int ST_TCP_SUM_DONE = 5;
   localparam int ST_IPV4_DONE    = 6;
   localparam int ST_INEXACT_PASS = 7;
   localparam int ST_IP_IDENT_VLD = 9;
   localparam int ST_FRAG_UDP_VLD = 10;
   localparam int ER_SYMBOL       = 5;
   localparam int ER_ORDER_FAULT  = 6;
   localparam int ER_CRC_ALIGN    = 4;
   localparam int ER_L4_SUM       = 9;
   localparam int ER_IPV4_SUM     = 10;
   localparam int ER_RX_DATA      = 11;
   localparam logic [STAT_W-1:0] STAT_RSVD_MASK = 20'hf0100;
   localparam logic [ERR_W-1:0]  ERR_RSVD_MASK  = 12'h18f;

   ////////////////////////////////////////////////////////////////////////////////
   // apb register map, byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_VET    = 8'h04;
   localparam logic [7:0] A_ISTAT  = 8'h08;
   localparam logic [7:0] A_IMASK  = 8'h0c;
   localparam logic [7:0] A_LAST_8 = 8'h10;
   localparam logic [7:0] A_LAST_0 = 8'h14;
   // control fields
   localparam int CT_SUM_EN   = 0;
   localparam int CT_L4_OFL   = 1;
   localparam int CT_FRAG_UDP = 2;
   localparam int CT_OFS_LSB  = 8;
   // interrupt events
   localparam int IRQ_W       = 2;
   localparam int EV_WB       = 0;
   localparam int EV_ERR      = 1;
   // reset values
   localparam logic [2:0]  CTRL_RST = 3'h0;
   localparam logic [7:0]  OFS_RST  = 8'h00;
   localparam logic [15:0] VET_RST  = 16'h8100;

endpackage
